/* File: core/serial_pkg.sv */
// Constants, register map and carrier types of the clocked serial channel
//
// Functional notes
// RL1 - Slave duplex setup: clocking register gets 07h
// RL2 - Length register written zero for eight bits
// RL3 - Single duplex enable: primary control gets E1h
// RL4 - Slave: transmit write sets active, awaits clock
// RL5 - Slave duplex shifts out and samples on clock
// RL6 - Single: stop after length, end event, clear
// RL7 - Slave duplex: read word, write next word
// RL8 - End session by clearing clock, transmit, receive
// RL9 - Continuous master transmit enable value is C3h
// RL10 - Continuous master duplex enable value is E3h
// RL11 - Master setup: clocking register written zero
// RL12 - Master: transmit write starts clocking at once
// RL13 - Continuous: event when word enters shifter
// RL14 - Continuous master: buffered word follows directly
// RL15 - Continuous master: no word, stop, clear active
// RL16 - Continuous transmit-only never raises reception end
// RL17 - Continuous duplex: every word raises reception end
// RL18 - Receive error raises error event; software reads
// RL19 - Software clears overrun flag by writing zero
// RL20 - Order zero MSB first; type 1 is 00
// RL21 - Clock select 111 external, 000 divided clock
// RL22 - Length field zero selects eight bits
// RL23 - Receive-only: dummy receive read starts reception; the code starts it only with the continue bit set
// RL24 - Continue bit: receive read starts next word
// RL25 - Unread word overwritten sets overrun flag
// RL26 - Software checks active flag before disabling
package serial_pkg;

	// Register byte addresses on the APB side
	localparam logic [7:0] CTL_PRIMARY_ADDR  = 8'h00;
	localparam logic [7:0] CTL_CLOCKING_ADDR = 8'h04;
	localparam logic [7:0] CTL_LENGTH_ADDR   = 8'h08;
	localparam logic [7:0] STATUS_ADDR       = 8'h0c;
	localparam logic [7:0] TX_DATA_ADDR      = 8'h10;
	localparam logic [7:0] RX_DATA_ADDR      = 8'h14;

	// Reset values
	localparam logic [7:0] CTL_PRIMARY_RST  = 8'h01;
	localparam logic [7:0] CTL_CLOCKING_RST = 8'h00;
	localparam logic [3:0] CTL_LENGTH_RST   = 4'h0;

	// Field positions
	localparam int STATUS_ACTIVE_BIT  = 7;
	localparam int STATUS_OVERRUN_BIT = 0;

	// Clock source encodings
	localparam logic [2:0] CKS_EXTERNAL = 3'h7;
	localparam logic [2:0] CKS_DIV4     = 3'h0;

	// Word length: field zero means eight, 1..7 add, 8..15 give sixteen
	localparam logic [4:0] BITS_DEFAULT = 5'h08;
	localparam logic [4:0] BITS_MAX     = 5'h10;
	localparam int         DATA_W       = 16;

	// Master serial clock is the system clock divided by four
	localparam int MASTER_DIV   = 4;
	localparam int HALF_PERIOD  = MASTER_DIV / 2;

	typedef struct packed {
		logic       channel_clock_enable;
		logic       transmit_enable_bit;
		logic       receive_enable_bit;
		logic       bit_order_select;
		logic [1:0] unused;
		logic       continuous_mode;
		logic       serial_continue_enable;
	} ctl_primary_t;

	typedef struct packed {
		logic [2:0] unused;
		logic       clock_polarity_select;
		logic       data_phase_select;
		logic [2:0] clock_source_select;
	} ctl_clocking_t;

	typedef struct packed {
		logic reception_end_event;
		logic transmit_enable_event;
		logic reception_error_event;
	} serial_events_t;

endpackage

/* File: core/serial_shift_engine.sv */
// Bit shifter and bit counter of one serial word
`timescale 1ns/1ns
module serial_shift_engine
	import serial_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         abort,
	input  wire logic         load,
	input  wire logic [W-1:0] load_data,
	input  wire logic [4:0]   nbits,
	input  wire logic         dir,
	input  wire logic         dap,
	input  wire logic         lead,
	input  wire logic         trail,
	input  wire logic         si,
	output logic              so,
	output logic [W-1:0]      rx_word,
	output logic              done,
	output logic              busy
);

	localparam int LW = $clog2(W);

	if (W != int'(BITS_MAX))
		$error("serial_shift_engine: W must equal the longest word");

	logic [W-1:0] tx_r;
	logic [W-1:0] rx_r;
	logic [W-1:0] rx_nxt;
	logic [4:0]   cnt_r;
	logic         in_edge;
	logic         last;

	function automatic logic bit_at(input logic [W-1:0] w,
		input logic [4:0] k, input logic [4:0] n, input logic d);
		logic [4:0] idx;
		idx = d ? k : 5'(n - 5'h01 - k);
		return w[idx[LW-1:0]];
	endfunction

	// Phase zero samples on the trailing edge, phase one on the leading
	assign in_edge = dap ? lead : trail;
	assign last    = busy && trail && (cnt_r == 5'(nbits - 5'h01));
	assign rx_nxt  = dir ? {si, rx_r[W-1:1]} : {rx_r[W-2:0], si};

	// RL6 stop after length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy <= 1'b0;
		else if (abort)
			busy <= 1'b0;
		else if (load)
			busy <= 1'b1;
		else if (last)
			busy <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= 5'h00;
		else if (load)
			cnt_r <= 5'h00;
		else if (busy && trail)
			cnt_r <= 5'(cnt_r + 5'h01);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_r <= '0;
		else if (load)
			tx_r <= load_data;
	end

	// RL5 shift out on clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			so <= 1'b1;
		else if (load && dap)
			so <= bit_at(load_data, 5'h00, nbits, dir);
		else if (busy && lead && !dap)
			so <= bit_at(tx_r, cnt_r, nbits, dir);
		else if (busy && trail && dap && !last)
			so <= bit_at(tx_r, 5'(cnt_r + 5'h01), nbits, dir);
	end

	// RL5 sample on clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_r <= '0;
		else if (busy && in_edge)
			rx_r <= rx_nxt;
	end

	// RL20 bit order alignment
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_word <= '0;
		else if (last && dir)
			rx_word <= (dap ? rx_r : rx_nxt) >> (5'(W) - nbits);
		else if (last)
			rx_word <= (dap ? rx_r : rx_nxt)
				& ({W{1'b1}} >> (5'(W) - nbits));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done <= 1'b0;
		else
			done <= last && !abort;
	end

endmodule

/* File: core/serial_channel.sv */
// Clocked serial channel with APB register slave
`timescale 1ns/1ns
module serial_channel
	import serial_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         serial_clock_pin_i,
	output logic              serial_clock_pin_o,
	output logic              serial_clock_pin_oe_n,
	output logic              serial_out_pin,
	input  wire logic         serial_in_pin,
	output serial_events_t    events,
	output logic              transfer_active_flag
);

	if (W != int'(BITS_MAX))
		$error("serial_channel: W must equal the longest word");

	ctl_primary_t  ctl0_r;
	ctl_clocking_t ctl1_r;
	logic [3:0]    ctl2_r;
	logic [W-1:0]  tx_buf_r;
	logic          tx_full_r;
	logic [W-1:0]  rx_reg_r;
	logic          rx_unread_r;
	logic          overrun_error_flag;
	logic          rx_go_r;
	logic [31:0]   rd_nxt;
	logic          mapped;
	logic          acc;
	logic          wr;
	logic          rd_rx;
	logic          master;
	logic          idle_lvl;
	logic          sck_q_r;
	logic [1:0]    div_r;
	logic          lead;
	logic          trail;
	logic          load;
	logic          done;
	logic          busy;
	logic [W-1:0]  rx_word;
	logic [4:0]    nbits;
	logic          pwr;
	logic          cont;

	//////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data latched in the setup cycle

	assign acc    = psel && penable;
	assign wr     = acc && pwrite && mapped;
	assign rd_rx  = acc && !pwrite && (paddr == RX_DATA_ADDR);
	assign pready = acc;

	always_comb
	begin
		mapped = 1'b1;
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			CTL_PRIMARY_ADDR:  rd_nxt[7:0] = ctl0_r;
			CTL_CLOCKING_ADDR: rd_nxt[7:0] = ctl1_r;
			CTL_LENGTH_ADDR:   rd_nxt[3:0] = ctl2_r;
			STATUS_ADDR:
			begin
				rd_nxt[STATUS_ACTIVE_BIT]  = transfer_active_flag;
				rd_nxt[STATUS_OVERRUN_BIT] = overrun_error_flag;
			end
			TX_DATA_ADDR:      rd_nxt[W-1:0] = tx_buf_r;
			RX_DATA_ADDR:      rd_nxt[W-1:0] = rx_reg_r;
			default:           mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl0_r <= CTL_PRIMARY_RST;
			ctl1_r <= CTL_CLOCKING_RST;
			ctl2_r <= CTL_LENGTH_RST;
		end
		else if (wr)
		begin
			if (paddr == CTL_PRIMARY_ADDR)
				ctl0_r <= pwdata[7:0];
			if (paddr == CTL_CLOCKING_ADDR)
				ctl1_r <= pwdata[7:0];
			if (paddr == CTL_LENGTH_ADDR)
				ctl2_r <= pwdata[3:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Mode decode

	assign pwr  = ctl0_r.channel_clock_enable;
	assign cont = ctl0_r.continuous_mode;

	// RL21 clock source select
	assign master = ctl1_r.clock_source_select != CKS_EXTERNAL;
	// RL20 polarity zero idles high
	assign idle_lvl = !ctl1_r.clock_polarity_select;

	// RL22 length field decode
	always_comb
	begin
		if (ctl2_r == 4'h0)
			nbits = BITS_DEFAULT;
		else if (ctl2_r[3])
			nbits = BITS_MAX;
		else
			nbits = 5'(BITS_DEFAULT + {1'b0, ctl2_r});
	end

	//////////////////////////////////////////////////////////////////////
	// Transmit buffer and start of a word

	// RL12 write starts transfer
	assign load = pwr && !busy
		&& (ctl0_r.transmit_enable_bit ? tx_full_r : rx_go_r);

	// RL4 write sets active
	assign transfer_active_flag = busy || tx_full_r || rx_go_r;

	// Single mode refuses a word while one is shifting
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_buf_r <= '0;
		else if (wr && paddr == TX_DATA_ADDR && (cont || !busy))
			tx_buf_r <= pwdata[W-1:0];
	end

	// RL14 buffered word follows
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_full_r <= 1'b0;
		else if (!pwr || !ctl0_r.transmit_enable_bit)
			tx_full_r <= 1'b0;
		else if (wr && paddr == TX_DATA_ADDR && (cont || !busy))
			tx_full_r <= 1'b1;
		else if (load)
			tx_full_r <= 1'b0;
	end

	// RL23 dummy read arms
	// RL24 continue bit restarts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_go_r <= 1'b0;
		else if (!pwr || ctl0_r.transmit_enable_bit
				|| !ctl0_r.receive_enable_bit)
			rx_go_r <= 1'b0;
		else if (load)
			rx_go_r <= 1'b0;
		else if (ctl0_r.serial_continue_enable
				&& ((rd_rx && !busy) || (done && cont)))
			rx_go_r <= 1'b1;
	end

	//////////////////////////////////////////////////////////////////////
	// Serial clock: divided in master role, followed in slave role

	// RL15 clock stops when idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_r <= 2'h0;
		else if (!busy || !master)
			div_r <= 2'h0;
		else if (div_r == 2'(HALF_PERIOD - 1))
			div_r <= 2'h0;
		else
			div_r <= 2'(div_r + 2'h1);
	end

	// Master drives the clock out; slave keeps a sampled copy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sck_q_r <= 1'b1;
		else if (!master)
			sck_q_r <= serial_clock_pin_i;
		else if (!busy)
			sck_q_r <= idle_lvl;
		else if (div_r == 2'(HALF_PERIOD - 1))
			sck_q_r <= !sck_q_r;
	end

	// RL4 slave waits for clock
	always_comb
	begin
		if (master)
		begin
			lead  = busy && div_r == 2'(HALF_PERIOD - 1)
				&& sck_q_r == idle_lvl;
			trail = busy && div_r == 2'(HALF_PERIOD - 1)
				&& sck_q_r != idle_lvl;
		end
		else
		begin
			lead  = sck_q_r == idle_lvl && serial_clock_pin_i != idle_lvl;
			trail = sck_q_r != idle_lvl && serial_clock_pin_i == idle_lvl;
		end
	end

	assign serial_clock_pin_o    = master ? sck_q_r : idle_lvl;
	// RL12 master drives clock
	assign serial_clock_pin_oe_n = !(master && pwr);

	serial_shift_engine #(
		.W (W)
	) serial_shift_engine_inst (
		.pclk      (pclk),
		.presetn   (presetn),
		.abort     (!pwr),
		.load      (load),
		.load_data (ctl0_r.transmit_enable_bit ? tx_buf_r : '0),
		.nbits     (nbits),
		.dir       (ctl0_r.bit_order_select),
		.dap       (ctl1_r.data_phase_select),
		.lead      (lead),
		.trail     (trail),
		.si        (serial_in_pin),
		.so        (serial_out_pin),
		.rx_word   (rx_word),
		.done      (done),
		.busy      (busy)
	);

	//////////////////////////////////////////////////////////////////////
	// Receive register, overrun and events

	// RL17 word readable at end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_reg_r <= '0;
		else if (done && ctl0_r.receive_enable_bit)
			rx_reg_r <= rx_word;
	end

	// New word wins over a read in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_unread_r <= 1'b0;
		else if (done && ctl0_r.receive_enable_bit)
			rx_unread_r <= 1'b1;
		else if (rd_rx)
			rx_unread_r <= 1'b0;
	end

	// RL25 overrun sets flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overrun_error_flag <= 1'b0;
		else if (done && ctl0_r.receive_enable_bit && rx_unread_r)
			overrun_error_flag <= 1'b1;
		else if (wr && paddr == STATUS_ADDR
				&& !pwdata[STATUS_OVERRUN_BIT])
			overrun_error_flag <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			events <= '0;
		else
		begin
			// RL6 end event
			// RL16 none in continuous transmit-only
			events.reception_end_event <= done
				&& (!cont || ctl0_r.receive_enable_bit);
			// RL13 word entered shifter
			events.transmit_enable_event <= load && cont
				&& ctl0_r.transmit_enable_bit;
			// RL18 error event
			events.reception_error_event <= done
				&& ctl0_r.receive_enable_bit && rx_unread_r;
		end
	end

endmodule

/* File: sim/serial_channel_monitor.sv */
// Port assertions for the serial channel
`timescale 1ns/1ns
module serial_channel_monitor
	import serial_pkg::*;
(
	input  wire logic     pclk,
	input  wire logic     presetn,
	input  wire logic     psel,
	input  wire logic     penable,
	input  wire logic     pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic     serial_clock_pin_o,
	input  wire logic     serial_clock_pin_oe_n,
	input  serial_events_t events,
	input  wire logic     transfer_active_flag
);
	logic       wr_now;
	logic [7:0] ctl_r;
	logic [2:0] src_r;
	assign wr_now = psel && penable && pwrite;
	// Shadow of the primary register and the clock source field, since mode is not visible at ports
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctl_r <= CTL_PRIMARY_RST;
		else if (wr_now && paddr == CTL_PRIMARY_ADDR)
			ctl_r <= pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			src_r <= CTL_CLOCKING_RST[2:0];
		else if (wr_now && paddr == CTL_CLOCKING_ADDR)
			src_r <= pwdata[2:0];
	end
	////////////////////////////////////////
	default clocking mon_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	idle_level_a: assert property (!transfer_active_flag |->
		serial_clock_pin_o)
		else $error("serial clock not idle high");
	clock_owner_a: assert property ($fell(serial_clock_pin_o) |->
		!serial_clock_pin_oe_n && transfer_active_flag)
		else $error("clock edge without drive");
	half_period_a: assert property ($fell(serial_clock_pin_o) |->
		##1 !serial_clock_pin_o ##1 serial_clock_pin_o)
		else $error("master clock not divided by four");
	end_pulse_a: assert property (events.reception_end_event |->
		serial_clock_pin_o ##1 !events.reception_end_event)
		else $error("reception end pulse wrong");
	tx_event_a: assert property (events.transmit_enable_event |->
		transfer_active_flag ##1 !events.transmit_enable_event)
		else $error("transmit enable pulse wrong");
	tx_only_a: assert property (ctl_r == 8'hc3 |->
		!events.reception_end_event)
		else $error("reception end in transmit only");
	active_set_a: assert property (wr_now && paddr == TX_DATA_ADDR &&
		ctl_r[7] && ctl_r[6] |=> transfer_active_flag)
		else $error("active flag not set by write");
	clock_off_a: assert property (!ctl_r[7] && !$past(ctl_r[7]) |->
		serial_clock_pin_oe_n)
		else $error("clock driven while disabled");
	ext_source_a: assert property (src_r == CKS_EXTERNAL &&
		$past(src_r) == CKS_EXTERNAL |-> serial_clock_pin_oe_n)
		else $error("clock driven in slave role");
	cover property (events.reception_end_event);
	cover property (events.transmit_enable_event);
	cover property (events.reception_error_event);
endmodule
bind serial_channel serial_channel_monitor serial_channel_monitor_inst
	(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.serial_clock_pin_o, .serial_clock_pin_oe_n, .events,
	.transfer_active_flag);

/* File: sim/serial_peer_model.sv */
// Far-side serial device model
`timescale 1ns/1ns
module serial_peer_model
(
	input  wire logic pclk,
	input  wire logic clk_o,
	input  wire logic oe_n,
	input  wire logic sout,
	output logic      sck,
	output logic      sin
);
	logic       ext_clk = 1'b1;
	logic [7:0] tx_w = 8'h00;
	logic [7:0] rx_w = 8'h00;
	assign sck = oe_n ? ext_clk : clk_o;
	initial
		sin = 1'b1;
	////////////////////////////////////////
	// output on falling
	// Inverted refill so the line never just repeats a stale bit
	always @(negedge sck)
	begin
		sin <= tx_w[7];
		tx_w <= {tx_w[6:0], ~tx_w[7]};
	end
	always @(posedge sck)
		rx_w <= {rx_w[6:0], sout};
	task automatic load(input logic [7:0] w);
		tx_w = w;
	endtask
	// external clock burst
	// Clock stands high outside frames
	task automatic burst(input int half);
		repeat (8)
		begin
			repeat (half) @(posedge pclk);
			ext_clk <= 1'b0;
			repeat (half) @(posedge pclk);
			ext_clk <= 1'b1;
		end
	endtask
endmodule

/* File: sim/clocked_serial_single_continuous_test.sv */
// Register-level bench for the serial channel
`timescale 1ns/1ns
module clocked_serial_single_continuous_test import serial_pkg::*;;
	logic           pclk, presetn, psel, penable, pwrite;
	logic           pready, pslverr, sck_i, sck_o, sck_oe_n;
	logic           sout, sin, active, e;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, q;
	serial_events_t events;
	int             err_count = 0, checked = 0;
	int             rend = 0, tev = 0, rerr = 0;
	serial_channel serial_channel_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.serial_clock_pin_i(sck_i), .serial_clock_pin_o(sck_o),
		.serial_clock_pin_oe_n(sck_oe_n), .serial_out_pin(sout),
		.serial_in_pin(sin), .events, .transfer_active_flag(active));
	serial_peer_model serial_peer_model_inst (.pclk, .clk_o(sck_o),
		.oe_n(sck_oe_n), .sout, .sck(sck_i), .sin);
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		if (events.reception_end_event === 1'b1)
			rend <= rend + 1;
		if (events.transmit_enable_event === 1'b1)
			tev <= tev + 1;
		if (events.reception_error_event === 1'b1)
			rerr <= rerr + 1;
	end
	////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	// Enter right after a rising edge; pready is awaited, never assumed
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input string n);
		apb(1'b0, a, 32'h0);
		chk(n, x, q);
	endtask
	task automatic wait_idle();
		@(posedge pclk);
		while (active !== 1'b0)
			@(posedge pclk);
		repeat (4) @(posedge pclk);
	endtask
	initial
	begin
		#50000;
		err_count++;
		final_report();
	end
	////////////////////////////////////////
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTL_PRIMARY_ADDR, 32'(CTL_PRIMARY_RST), "primary reset");
		rd(CTL_CLOCKING_ADDR, 32'(CTL_CLOCKING_RST), "clocking reset");
		rd(CTL_LENGTH_ADDR, 32'(CTL_LENGTH_RST), "length reset");
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, 32'(e));
		wr(CTL_CLOCKING_ADDR, 32'h00);
		wr(CTL_LENGTH_ADDR, 32'h00);
		wr(CTL_PRIMARY_ADDR, 32'he1);
		serial_peer_model_inst.load(8'h5a);
		wr(TX_DATA_ADDR, 32'ha5);
		wait_idle();
		chk("peer word", 32'ha5, 32'(serial_peer_model_inst.rx_w));
		rd(RX_DATA_ADDR, 32'h5a, "rx word");
		rd(STATUS_ADDR, 32'h0, "status");
		chk("end events", 32'd1, 32'(rend));
		wr(CTL_PRIMARY_ADDR, 32'he3);
		serial_peer_model_inst.load(8'h5a);
		wr(TX_DATA_ADDR, 32'h3c);
		while (tev == 0)
			@(posedge pclk);
		wr(TX_DATA_ADDR, 32'hc3);
		wait_idle();
		chk("end events", 32'd3, 32'(rend));
		chk("tx events", 32'd2, 32'(tev));
		chk("error events", 32'd1, 32'(rerr));
		chk("peer word", 32'hc3, 32'(serial_peer_model_inst.rx_w));
		rd(STATUS_ADDR, 32'h01, "overrun");
		rd(RX_DATA_ADDR, 32'ha5, "rx word");
		wr(STATUS_ADDR, 32'h0);
		rd(STATUS_ADDR, 32'h0, "overrun cleared");
		wr(CTL_PRIMARY_ADDR, 32'hc3);
		wr(TX_DATA_ADDR, 32'h81);
		wait_idle();
		chk("end events", 32'd3, 32'(rend));
		chk("peer word", 32'h81, 32'(serial_peer_model_inst.rx_w));
		rd(STATUS_ADDR, 32'h0, "idle before off");
		wr(CTL_PRIMARY_ADDR, 32'ha1);
		serial_peer_model_inst.load(8'h3c);
		rd(RX_DATA_ADDR, 32'ha5, "dummy read");
		wait_idle();
		rd(RX_DATA_ADDR, 32'h3c, "rx only word");
		wait_idle();
		wr(CTL_PRIMARY_ADDR, 32'ha0);
		rd(RX_DATA_ADDR, 32'hc3, "last rx word");
		rd(STATUS_ADDR, 32'h0, "no restart");
		chk("end events", 32'd5, 32'(rend));
		wr(CTL_PRIMARY_ADDR, 32'h00);
		wr(CTL_CLOCKING_ADDR, 32'h07);
		wr(CTL_PRIMARY_ADDR, 32'he1);
		serial_peer_model_inst.load(8'h69);
		wr(TX_DATA_ADDR, 32'h96);
		rd(STATUS_ADDR, 32'h80, "active waiting");
		serial_peer_model_inst.burst(4);
		wait_idle();
		chk("peer word", 32'h96, 32'(serial_peer_model_inst.rx_w));
		rd(RX_DATA_ADDR, 32'h69, "slave rx");
		chk("end events", 32'd6, 32'(rend));
		serial_peer_model_inst.load(8'h0f);
		wr(TX_DATA_ADDR, 32'hf0);
		rd(STATUS_ADDR, 32'h80, "second wait");
		serial_peer_model_inst.burst(4);
		wait_idle();
		chk("peer word", 32'hf0, 32'(serial_peer_model_inst.rx_w));
		rd(RX_DATA_ADDR, 32'h0f, "slave rx again");
		chk("end events", 32'd7, 32'(rend));
		wr(CTL_PRIMARY_ADDR, 32'h00);
		chk("clock released", 32'h1, 32'(sck_oe_n));
		final_report();
	end
endmodule
